/* hcp_debounce.sv */
// Purpose: Shared constants of the host control block, and the
//          two-flop synchroniser with two-sample debounce for the pins.
// Assumes: One clock; pins are asynchronous to it.
// Notes:   A new level is taken only after two equal samples in a row.

`timescale 1ns/1ns

package hcp_pkg;
    // ------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------
    localparam int CMD_BITS = 8;
    localparam int PEAK_BITS = 16;
    localparam logic [3:0] ADDR_BANK = 4'h0;
    localparam logic [3:0] ADDR_FADE = 4'h1;
    localparam logic [3:0] ADDR_DCVOL = 4'h4;
    localparam logic [3:0] ADDR_MODE = 4'h6;
    localparam int ADDR_MSB = 3;
    localparam int RST_BIT = 1;
    // Debounce sample enable divider (1 = every clock)
    localparam int SAMPLE_DIV = 1;
    // ------------------------------------------------------------
    // Register file reset values, index 0 to 9
    // ------------------------------------------------------------
    localparam logic [3:0] INIT_BANK = 4'h3;
    localparam logic [3:0] INIT_FADE_A = 4'h0;
    localparam logic [3:0] INIT_FADE_B = 4'h2;
    localparam logic [3:0] INIT_FADE_C = 4'h8;
    localparam logic [3:0] INIT_DCVOL_A = 4'h7;
    localparam logic [3:0] INIT_DCVOL_B = 4'h0;
    localparam logic [3:0] INIT_DCVOL_C = 4'hD;
    localparam logic [3:0] INIT_MODE_A = 4'h0;
    localparam logic [3:0] INIT_MODE_B = 4'h0;
    localparam logic [3:0] INIT_MODE_C = 4'h8;
    localparam int NUM_CTL = 10;
    localparam logic [39:0] CTL_INIT = {INIT_MODE_C, INIT_MODE_B,
        INIT_MODE_A, INIT_DCVOL_C, INIT_DCVOL_B, INIT_DCVOL_A,
        INIT_FADE_C, INIT_FADE_B, INIT_FADE_A, INIT_BANK};
    localparam logic [3:0] NO_REG = 4'hF;
endpackage : hcp_pkg

module hcp_debounce #(
    parameter int WIDTH = 3,
    parameter int DIV = hcp_pkg::SAMPLE_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin,
    input wire logic [WIDTH-1:0] init_level,
    output logic [WIDTH-1:0] level
);
    // Refuse settings the divider counter and flops cannot serve
    if (DIV < 1 || DIV > 65535 || WIDTH < 1) begin : g_bad_param
        $error("hcp_debounce: bad parameters");
    end

    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] last;
    logic [15:0] div_cnt;
    logic sample_en;
    logic [15:0] next_div_cnt;
    logic next_sample_en;
    logic [WIDTH-1:0] next_last;
    logic [WIDTH-1:0] next_level;

    // ------------------------------------------------------------
    // Synchroniser: first flop feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        sync1 <= pin;
        sync2 <= sync1;
    end

    // Sample enable and two-sample acceptance
    always_comb begin
        next_div_cnt = div_cnt + 16'h0001;
        next_sample_en = 1'b0;
        if (div_cnt >= 16'(DIV - 1)) begin
            next_div_cnt = 16'h0000;
            next_sample_en = 1'b1;
        end
        next_last = last;
        next_level = level;
        if (sample_en) begin
            next_last = sync2;
            next_level = (sync2 == last) ? sync2 : level;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt <= 16'h0000;
            sample_en <= 1'b0;
            last <= init_level;
            level <= init_level;
        end else begin
            div_cnt <= next_div_cnt;
            sample_en <= next_sample_en;
            last <= next_last;
            level <= next_level;
        end
    end
endmodule : hcp_debounce

/* hcp_host_ctrl.sv */
// Purpose: Three-line host command interpreter and stereo peak read-out.
// Assumes: Peak samples arrive as signed words on the MCLK domain.
// Notes:   Data line is split into in, out and active-low enable.

`timescale 1ns/1ns

module hcp_host_ctrl (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CMD_REQ_SELECT,
    input wire logic HOST_SHIFT_CLOCK,
    input wire logic HOST_SERIAL_LINE_IN,
    output logic HOST_SERIAL_LINE_OUT,
    output logic HOST_SERIAL_LINE_OE_N,
    input wire logic SAMPLE_VALID,
    input wire logic [15:0] SAMPLE_LEFT,
    input wire logic [15:0] SAMPLE_RIGHT,
    output logic [1:0] BANK_SEL,
    output logic ATTENUATE_BIT,
    output logic MUTE_BIT,
    output logic FADE_ENABLE,
    output logic DITHER_ENABLE,
    output logic [9:0] FADE_SPEED,
    output logic DC_ENABLE,
    output logic DC_HOLD,
    output logic [9:0] VOLUME,
    output logic [1:0] DEEMPH_SEL,
    output logic DEEMPH_ON,
    output logic [1:0] IN_FORMAT_SEL,
    output logic IN_FORMAT_ALT,
    output logic [1:0] OUT_RATE_IND,
    output logic OUT_RATE_DEFINED,
    output logic SHAPER_ORDER_BIT,
    output logic STANDBY_BIT,
    output logic PEAK_REQ_ACTIVE
);
    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_WAIT = 2'b01,
        ST_PEAK = 2'b10
    } hcp_state_t;

    // Register index for an address and bank; NO_REG if unmapped
    function automatic logic [3:0] reg_index(input logic [3:0] addr,
                                             input logic [1:0] bank);
        logic [3:0] base;
        base = hcp_pkg::NO_REG;
        if (addr == hcp_pkg::ADDR_FADE) begin
            base = 4'h0;
        end else if (addr == hcp_pkg::ADDR_DCVOL) begin
            base = 4'h3;
        end else if (addr == hcp_pkg::ADDR_MODE) begin
            base = 4'h6;
        end
        if (addr == hcp_pkg::ADDR_BANK) begin
            reg_index = 4'h0;
        end else if (base == hcp_pkg::NO_REG || bank == 2'b00) begin
            reg_index = hcp_pkg::NO_REG;
        end else begin
            reg_index = base + {2'b00, bank};
        end
    endfunction : reg_index

    // Magnitude of a signed sample
    function automatic logic [15:0] mag(input logic [15:0] s);
        mag = s[15] ? 16'(~s + 16'h0001) : s;
    endfunction : mag

    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    logic [2:0] pins;
    logic sel;
    logic clk_line;
    logic data_line;

    hcp_debounce #(
        .WIDTH(3),
        .DIV(hcp_pkg::SAMPLE_DIV)
    ) u_debounce (
        .clk(MCLK),
        .rst(RST),
        .pin({CMD_REQ_SELECT, HOST_SHIFT_CLOCK, HOST_SERIAL_LINE_IN}),
        .init_level(3'h7),
        .level(pins)
    );

    assign sel = pins[2];
    assign clk_line = pins[1];
    assign data_line = pins[0];

    // ------------------------------------------------------------
    // Serial state and register file
    // ------------------------------------------------------------
    hcp_state_t state;
    hcp_state_t next_state;
    logic sel_prev;
    logic clk_prev;
    logic [6:0] cmd_sh;
    logic [6:0] next_cmd_sh;
    logic [2:0] cmd_cnt;
    logic [2:0] next_cmd_cnt;
    logic [31:0] peak_sh;
    logic [31:0] next_peak_sh;
    logic da_out;
    logic next_da_out;
    logic da_oe_n;
    logic next_da_oe_n;
    logic clear_peak;
    logic next_clear_peak;
    logic [3:0] ctl [0:hcp_pkg::NUM_CTL-1];
    logic [3:0] next_ctl [0:hcp_pkg::NUM_CTL-1];
    logic [15:0] peak_out_l;
    logic [15:0] peak_out_r;
    logic clk_rise;
    logic sel_rise;
    logic peak_act;

    assign clk_rise = clk_line & ~clk_prev;
    assign sel_rise = sel & ~sel_prev;

    // Position of the address MSB within the command word
    localparam int ADDR_MSB_POS = 4 + hcp_pkg::ADDR_MSB;

    // Next serial state, command decode and peak shift-out
    always_comb begin
        logic [7:0] cmd;
        logic [3:0] idx;
        logic [1:0] bank;
        cmd = {cmd_sh, data_line};
        bank = {ctl[0][3], ctl[0][2]};
        idx = reg_index(cmd[7:4], bank);
        next_state = state;
        next_cmd_sh = cmd_sh;
        next_cmd_cnt = cmd_cnt;
        next_peak_sh = peak_sh;
        next_da_out = da_out;
        next_da_oe_n = da_oe_n;
        next_clear_peak = 1'b0;
        for (int i = 0; i < hcp_pkg::NUM_CTL; i++) begin
            next_ctl[i] = ctl[i];
        end
        unique case (state)
            ST_CMD: begin
                next_da_oe_n = 1'b1;
                if (sel_rise) begin
                    next_cmd_cnt = 3'h0;
                    if (clk_line) begin
                        next_state = ST_PEAK;
                        next_peak_sh = {peak_out_l, peak_out_r};
                        next_da_out = 1'b0;
                        next_da_oe_n = 1'b0;
                    end else begin
                        next_state = ST_WAIT;
                    end
                end else if (!sel && clk_rise) begin
                    next_cmd_sh = cmd[6:0];
                    next_cmd_cnt = cmd_cnt + 3'h1;
                    if (cmd_cnt == 3'(hcp_pkg::CMD_BITS - 1)) begin
                        if (!cmd[ADDR_MSB_POS] &&
                            idx != hcp_pkg::NO_REG) begin
                            next_ctl[idx] = cmd[3:0];
                            if (idx == 4'(hcp_pkg::NUM_CTL - 1) &&
                                cmd[hcp_pkg::RST_BIT]) begin
                                for (int i = 0; i < hcp_pkg::NUM_CTL;
                                     i++) begin
                                    next_ctl[i] =
                                        hcp_pkg::CTL_INIT[i*4 +: 4];
                                end
                            end
                        end
                    end
                end
            end
            ST_WAIT: begin
                if (!sel) begin
                    next_state = ST_CMD;
                end
            end
            ST_PEAK: begin
                if (!sel) begin
                    next_state = ST_CMD;
                    next_da_oe_n = 1'b1;
                    next_clear_peak = 1'b1;
                end else if (clk_rise) begin
                    next_da_out = peak_sh[31];
                    next_peak_sh = {peak_sh[30:0], 1'b0};
                end
            end
            default: begin
                next_state = ST_CMD;
                next_da_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state <= ST_CMD;
            peak_act <= 1'b0;
            sel_prev <= 1'b1;
            clk_prev <= 1'b1;
            cmd_sh <= 7'h00;
            cmd_cnt <= 3'h0;
            peak_sh <= 32'h0000_0000;
            da_out <= 1'b1;
            da_oe_n <= 1'b1;
            clear_peak <= 1'b0;
            for (int i = 0; i < hcp_pkg::NUM_CTL; i++) begin
                ctl[i] <= hcp_pkg::CTL_INIT[i*4 +: 4];
            end
        end else begin
            state <= next_state;
            peak_act <= ~next_da_oe_n;
            sel_prev <= sel;
            clk_prev <= clk_line;
            cmd_sh <= next_cmd_sh;
            cmd_cnt <= next_cmd_cnt;
            peak_sh <= next_peak_sh;
            da_out <= next_da_out;
            da_oe_n <= next_da_oe_n;
            clear_peak <= next_clear_peak;
            for (int i = 0; i < hcp_pkg::NUM_CTL; i++) begin
                ctl[i] <= next_ctl[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Peak detection and output register
    // ------------------------------------------------------------
    logic [15:0] acc_l;
    logic [15:0] acc_r;
    logic [15:0] next_acc_l;
    logic [15:0] next_acc_r;
    logic [15:0] next_out_l;
    logic [15:0] next_out_r;

    // Track largest magnitude; copy to output unless a request holds it
    always_comb begin
        next_acc_l = acc_l;
        next_acc_r = acc_r;
        next_out_l = peak_out_l;
        next_out_r = peak_out_r;
        if (clear_peak) begin
            next_acc_l = SAMPLE_VALID ? mag(SAMPLE_LEFT) : 16'h0000;
            next_acc_r = SAMPLE_VALID ? mag(SAMPLE_RIGHT) : 16'h0000;
        end else if (state != ST_PEAK) begin
            if (SAMPLE_VALID && mag(SAMPLE_LEFT) > acc_l) begin
                next_acc_l = mag(SAMPLE_LEFT);
            end
            if (SAMPLE_VALID && mag(SAMPLE_RIGHT) > acc_r) begin
                next_acc_r = mag(SAMPLE_RIGHT);
            end
        end
        if (state != ST_PEAK && next_state != ST_PEAK) begin
            next_out_l = next_acc_l;
            next_out_r = next_acc_r;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            acc_l <= 16'h0000;
            acc_r <= 16'h0000;
            peak_out_l <= 16'h0000;
            peak_out_r <= 16'h0000;
        end else begin
            acc_l <= next_acc_l;
            acc_r <= next_acc_r;
            peak_out_l <= next_out_l;
            peak_out_r <= next_out_r;
        end
    end

    // ------------------------------------------------------------
    // Decoded mode outputs
    // ------------------------------------------------------------
    logic deemph_on;
    logic fmt_alt;
    logic rate_def;

    // Registered decode of selector fields; reserved bits unused
    always_ff @(posedge MCLK) begin
        if (RST) begin
            deemph_on <= 1'b0;
            fmt_alt <= 1'b0;
            rate_def <= 1'b1;
        end else begin
            deemph_on <= (ctl[7][3:2] != 2'b00);
            fmt_alt <= (ctl[8][3:2] != 2'b00);
            rate_def <= (ctl[8][1:0] != 2'b10);
        end
    end

    // Output wiring from serial-state, register-file and decode flops
    assign HOST_SERIAL_LINE_OUT = da_out;
    assign HOST_SERIAL_LINE_OE_N = da_oe_n;
    assign PEAK_REQ_ACTIVE = peak_act;
    assign BANK_SEL = {ctl[0][3], ctl[0][2]};
    assign ATTENUATE_BIT = ctl[0][1];
    assign MUTE_BIT = ctl[0][0];
    assign FADE_ENABLE = ctl[1][3];
    assign DITHER_ENABLE = ctl[1][2];
    assign FADE_SPEED = {ctl[1][1:0], ctl[2], ctl[3]};
    assign DC_ENABLE = ctl[4][3];
    assign DC_HOLD = ctl[4][2];
    assign VOLUME = {ctl[4][1:0], ctl[5], ctl[6]};
    assign DEEMPH_SEL = ctl[7][3:2];
    assign DEEMPH_ON = deemph_on;
    assign IN_FORMAT_SEL = ctl[8][3:2];
    assign IN_FORMAT_ALT = fmt_alt;
    assign OUT_RATE_IND = ctl[8][1:0];
    assign OUT_RATE_DEFINED = rate_def;
    assign SHAPER_ORDER_BIT = ctl[9][2];
    assign STANDBY_BIT = ctl[9][0];
    // Reserved bits ctl[7][1:0] and ctl[9][3] drive nothing
endmodule : hcp_host_ctrl

/* hcp_host_ctrl_asserts.sv */
// Purpose: Port-level checks for the host control block.
// Assumes: Host holds each pin level at least 8 clocks.
// Notes:   Bound to hcp_host_ctrl below.
`timescale 1ns/1ns
module hcp_host_ctrl_asserts (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CMD_REQ_SELECT,
    input wire logic HOST_SHIFT_CLOCK,
    input wire logic HOST_SERIAL_LINE_OUT,
    input wire logic HOST_SERIAL_LINE_OE_N,
    input wire logic [9:0] VOLUME,
    input wire logic [1:0] DEEMPH_SEL,
    input wire logic DEEMPH_ON,
    input wire logic [1:0] IN_FORMAT_SEL,
    input wire logic IN_FORMAT_ALT,
    input wire logic [1:0] OUT_RATE_IND,
    input wire logic OUT_RATE_DEFINED,
    input wire logic PEAK_REQ_ACTIVE
);
    // ------------------------------------------------------------
    // Line and decode relations
    // ------------------------------------------------------------
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Request raised while clock high, then acknowledge
    sequence s_req_seen;
        $rose(CMD_REQ_SELECT) && HOST_SHIFT_CLOCK;
    endsequence
    sequence s_ack;
        ##[3:6] !HOST_SERIAL_LINE_OE_N;
    endsequence
    a_ack_after_req: assert property (s_req_seen |-> s_ack)
        else $error("no acknowledge after peak request");
    a_ack_is_low: assert property (
        $fell(HOST_SERIAL_LINE_OE_N) |-> !HOST_SERIAL_LINE_OUT)
        else $error("acknowledge not driven low");
    a_drive_needs_req: assert property (
        $fell(HOST_SERIAL_LINE_OE_N) |-> $past(CMD_REQ_SELECT, 2))
        else $error("line driven without request");
    a_idle_release: assert property (
        (!CMD_REQ_SELECT) [*8] |-> HOST_SERIAL_LINE_OE_N)
        else $error("line driven in command mode");
    a_bit_on_rise: assert property (
        (!HOST_SERIAL_LINE_OE_N && !$past(HOST_SERIAL_LINE_OE_N)
        && $changed(HOST_SERIAL_LINE_OUT)) |-> $past(HOST_SHIFT_CLOCK, 2))
        else $error("peak bit changed without clock rise");
    a_deemph_decode: assert property (
        DEEMPH_ON == ($past(DEEMPH_SEL) != 2'h0))
        else $error("de-emphasis enable decode wrong");
    a_format_decode: assert property (
        IN_FORMAT_ALT == ($past(IN_FORMAT_SEL) != 2'h0))
        else $error("input format decode wrong");
    a_rate_decode: assert property (
        OUT_RATE_DEFINED == ($past(OUT_RATE_IND) != 2'h2))
        else $error("rate indication decode wrong");
    a_no_cmd_in_req: assert property (
        PEAK_REQ_ACTIVE |-> $stable(VOLUME) && $stable(DEEMPH_SEL))
        else $error("control changed during peak request");
endmodule : hcp_host_ctrl_asserts

bind hcp_host_ctrl hcp_host_ctrl_asserts u_chk (.MCLK, .RST,
    .CMD_REQ_SELECT, .HOST_SHIFT_CLOCK, .HOST_SERIAL_LINE_OUT,
    .HOST_SERIAL_LINE_OE_N, .VOLUME, .DEEMPH_SEL, .DEEMPH_ON,
    .IN_FORMAT_SEL, .IN_FORMAT_ALT, .OUT_RATE_IND, .OUT_RATE_DEFINED,
    .PEAK_REQ_ACTIVE);

/* hcp_host_model.sv */
// Purpose: Microprocessor side of the three-line host bus.
// Assumes: Line level is resolved by the bench, pull-up when free.
// Notes:   hold sets clocks per shift-clock phase.
`timescale 1ns/1ns
module hcp_host_model (
    input wire logic clk,
    input wire logic line,
    output logic sel,
    output logic sclk,
    output logic dat,
    output logic dat_oe
);
    int hold = 8;
    // Idle in command mode, clock high
    initial begin
        sel = 1'b0;
        sclk = 1'b1;
        dat = 1'b1;
        dat_oe = 1'b1;
    end
    // Wait a number of clocks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // One clock low-high phase
    task automatic pulse;
        sclk <= 1'b0;
        tick(hold);
        sclk <= 1'b1;
        tick(hold);
    endtask : pulse
    // Command burst, address then data, MSB first
    task automatic put_cmd(input logic [3:0] a, input logic [3:0] d);
        logic [7:0] w;
        w = {a, d};
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk);
            dat <= w[i];
            pulse();
        end
    endtask : put_cmd
    // Raise request while clock high, wait for acknowledge
    task automatic req(output bit ok);
        ok = 1'b0;
        @(posedge clk);
        dat_oe <= 1'b0;
        sel <= 1'b1;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(posedge clk);
            ok = (line === 1'b0);
        end
    endtask : req
    // Collect n peak bits after acknowledge
    task automatic read(input int n, output logic [31:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin
            pulse();
            v = {v[30:0], line};
        end
    endtask : read
    // End request, then take the line back
    task automatic end_req;
        @(posedge clk);
        sel <= 1'b0;
        tick(hold);
        dat_oe <= 1'b1;
    endtask : end_req
endmodule : hcp_host_model

/* tb_hcp_host_ctrl.sv */
// Purpose: Self-checking bench for the host control block.
// Assumes: Command and peak traffic through the host model.
// Notes:   Expected values worked out from the register layout.
`timescale 1ns/1ns
module tb_hcp_host_ctrl;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic svalid = 1'b0;
    logic [15:0] sl = 16'h0000;
    logic [15:0] sr = 16'h0000;
    logic sel, sclk, dat, dat_oe, out, oe_n, attenuate_bit, mute, fen, den;
    logic dc_en, dc_hold, dm_on, fmt_alt, rate_def, ns, standby_bit, req_act;
    logic [1:0] bank, dm_sel, fmt_sel, rate;
    logic [9:0] fspeed, volume;
    logic [31:0] v;
    wire logic line;
    bit ok;
    int errors = 0;
    int comparisons = 0;
    // Clock and wire resolution
    always #5 mclk = ~mclk;
    assign line = !oe_n ? out : (dat_oe ? dat : 1'b1);
    hcp_host_model host (.clk(mclk), .line(line), .sel(sel),
        .sclk(sclk), .dat(dat), .dat_oe(dat_oe));
    hcp_host_ctrl dut (.MCLK(mclk), .RST(rst), .CMD_REQ_SELECT(sel),
        .HOST_SHIFT_CLOCK(sclk), .HOST_SERIAL_LINE_IN(line),
        .HOST_SERIAL_LINE_OUT(out), .HOST_SERIAL_LINE_OE_N(oe_n),
        .SAMPLE_VALID(svalid), .SAMPLE_LEFT(sl), .SAMPLE_RIGHT(sr),
        .BANK_SEL(bank), .ATTENUATE_BIT(attenuate_bit), .MUTE_BIT(mute),
        .FADE_ENABLE(fen), .DITHER_ENABLE(den), .FADE_SPEED(fspeed),
        .DC_ENABLE(dc_en), .DC_HOLD(dc_hold), .VOLUME(volume),
        .DEEMPH_SEL(dm_sel), .DEEMPH_ON(dm_on), .IN_FORMAT_SEL(fmt_sel),
        .IN_FORMAT_ALT(fmt_alt), .OUT_RATE_IND(rate),
        .OUT_RATE_DEFINED(rate_def), .SHAPER_ORDER_BIT(ns),
        .STANDBY_BIT(standby_bit), .PEAK_REQ_ACTIVE(req_act));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("Counts: comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic push(input logic [15:0] l, input logic [15:0] r);
        @(posedge mclk);
        svalid <= 1'b1;
        sl <= l;
        sr <= r;
        @(posedge mclk);
        svalid <= 1'b0;
    endtask : push
    task automatic ask;
        host.req(ok);
        if (!ok) begin
            errors++;
            $display("Error ack expected 0 seen %b", line);
            finish_test();
        end
    endtask : ask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("volume", 16'h030D, 16'(volume));
        chk("fade", 16'h0028, 16'({fen, den, fspeed}));
        chk("reg0", 16'h0003, 16'({bank, attenuate_bit, mute}));
        chk("dc", 16'h0001, 16'({dc_en, dc_hold}));
        chk("oe_n", 16'h0001, 16'(oe_n));
        $display("Test reset values done");
        host.put_cmd(4'h0, 4'h4);
        host.put_cmd(4'h1, 4'h5);
        chk("fade", 16'h0528, 16'({fen, den, fspeed}));
        host.put_cmd(4'h0, 4'hD);
        chk("reg0", 16'h000D, 16'({bank, attenuate_bit, mute}));
        host.put_cmd(4'h4, 4'h2);
        chk("volume", 16'h0302, 16'(volume));
        host.put_cmd(4'hC, 4'h5);
        chk("volume", 16'h0302, 16'(volume));
        host.put_cmd(4'h6, 4'hD);
        chk("ns_standby_bit", 16'h0003, 16'({ns, standby_bit}));
        host.put_cmd(4'h6, 4'h0);
        chk("ns_standby_bit", 16'h0000, 16'({ns, standby_bit}));
        host.put_cmd(4'h0, 4'h4);
        for (int i = 0; i < 4; i++) begin
            host.put_cmd(4'h6, {i[1:0], 2'h3});
            chk("deemph", 16'({i != 0, i[1:0]}), 16'({dm_on, dm_sel}));
            chk("fmt", 16'h0000, 16'({fmt_sel, ns}));
        end
        host.put_cmd(4'h0, 4'h8);
        for (int i = 0; i < 4; i++) begin
            host.put_cmd(4'h6, {i[1:0], i[1:0]});
            chk("fmt", 16'({i != 0, i[1:0]}), 16'({fmt_alt, fmt_sel}));
            chk("rate", 16'({i != 2, i[1:0]}), 16'({rate_def, rate}));
        end
        host.put_cmd(4'h0, 4'hC);
        host.put_cmd(4'h6, 4'h2);
        chk("volume", 16'h030D, 16'(volume));
        chk("reg0", 16'h0003, 16'({bank, attenuate_bit, mute}));
        chk("fields", 16'h0000, 16'({dm_sel, fmt_sel, rate}));
        chk("fade", 16'h0028, 16'({fen, den, fspeed}));
        host.put_cmd(4'h0, 4'hC);
        host.put_cmd(4'h6, 4'h1);
        chk("bank_standby_bit", 16'h0007, 16'({bank, standby_bit}));
        $display("Test command writes done");
        push(16'hFED4, 16'h0005);
        push(16'h0064, 16'h8000);
        repeat (4) @(posedge mclk);
        ask();
        chk("ack", 16'h0000, 16'({oe_n, out}));
        chk("req_act", 16'h0001, 16'(req_act));
        push(16'h7000, 16'h7000);
        host.read(32, v);
        chk("left", 16'h012C, v[31:16]);
        chk("right", 16'h8000, v[15:0]);
        host.end_req();
        push(16'hFFF0, 16'h9000);
        repeat (4) @(posedge mclk);
        host.hold = 12;
        ask();
        host.read(20, v);
        chk("left2", 16'h0010, v[19:4]);
        chk("right2", 16'h0007, 16'(v[3:0]));
        host.end_req();
        chk("oe_n", 16'h0001, 16'(oe_n));
        chk("req_act", 16'h0000, 16'(req_act));
        $display("Test peak read-out done");
        finish_test();
    end
endmodule : tb_hcp_host_ctrl
